// >>> verilog/overlay_key_params.svh
// Purpose: Register indices, field positions, reset values of the overlay key bank
// Assumes: Byte address on the bus is four times a register index
// Notes:   Definitions only
`ifndef OVERLAY_KEY_PARAMS_SVH
`define OVERLAY_KEY_PARAMS_SVH

// ---------------------------------------------------------------
// Register indices (byte address = index * 4)
// ---------------------------------------------------------------
`define IDX_DISP_CTRL  10'h200
`define IDX_AVG_RED    10'h310
`define IDX_AVG_GREEN  10'h312
`define IDX_AVG_BLUE   10'h314
`define IDX_AND_RED    10'h316
`define IDX_AND_GREEN  10'h318
`define IDX_AND_BLUE   10'h31A
`define IDX_OR_RED     10'h31C
`define IDX_FUNC_EN    10'h330
`define IDX_STATUS     10'h332

// ---------------------------------------------------------------
// Field positions and values
// ---------------------------------------------------------------
`define MODE_MSB       9
`define MODE_LSB       8
`define MODE_OVERLAY   2'h3
`define BYPASS_MSB     5
`define BYPASS_LSB     4
`define KEY_RESET      8'h00
`define CTRL_RESET     16'h0000
`define FUNC_EN_RESET  5'h00

`endif

// >>> verilog/overlay_key_pkg.sv
// Purpose: Types shared by the overlay key bank modules
// Assumes: Nothing beyond the parameter header
// Notes:   Function codes after FUNC_NONE follow rank order; priority lives in the datapath
package overlay_key_pkg;
    // Key function selected for a pixel
    typedef enum logic [2:0] {
        FUNC_NONE, FUNC_TRANS, FUNC_AVG, FUNC_AND, FUNC_OR, FUNC_INV
    } key_func_t;

    // One 24-bit colour, red in the top byte
    typedef logic [23:0] rgb_t;

    // Byte address to register index
    function automatic logic [9:0] addr_to_index(input logic [11:0] addr);
        return addr[11:2];
    endfunction : addr_to_index
endpackage : overlay_key_pkg

// >>> verilog/reg_access_if.sv
// Purpose: Carries decoded register accesses from the bus front end to the bank
// Assumes: Single clock domain
// Notes:   rdata is combinational from the bank
`timescale 1ns/1ns
`default_nettype none
interface reg_access_if;
    logic       wr_commit; // One-cycle write strobe
    logic [9:0] index;     // Register index
    logic [15:0] wdata;    // Write data, low half of the bus word
    logic [1:0] be;        // Byte enables of the low half
    logic [15:0] rdata;    // Read value of the addressed register

    modport front (output wr_commit, output index, output wdata, output be, input rdata);
    modport bank (input wr_commit, input index, input wdata, input be, output rdata);
endinterface : reg_access_if
`default_nettype wire

// >>> verilog/key_match.sv
// Purpose: Compares one pixel against one key colour
// Assumes: Both colours are full 8-bit components
// Notes:   Purely combinational
`timescale 1ns/1ns
`default_nettype none
module key_match
    import overlay_key_pkg::*;
(
    // Colours
    input wire rgb_t pixel_i,
    input wire rgb_t key_i,
    // Result
    output logic hit_o
);
    // All three components must agree
    always_comb begin
        hit_o = (pixel_i[23:16] == key_i[23:16]) && (pixel_i[15:8] == key_i[15:8])
            && (pixel_i[7:0] == key_i[7:0]);
    end
endmodule : key_match
`default_nettype wire

// >>> verilog/avalon_front.sv
// Purpose: Avalon-MM slave handshake for the overlay key bank
// Assumes: Master holds its request until it sees waitrequest low
// Notes:   Fixed answer one cycle after the request is first seen
`timescale 1ns/1ns
`default_nettype none
module avalon_front
    import overlay_key_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Avalon-MM slave
    input wire logic [11:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    // Toward the bank
    reg_access_if.front acc
);
    // Handshake state
    typedef struct packed {
        logic waitreq;
        logic [15:0] rdata;
    } front_state_t;

    front_state_t st;
    front_state_t next_st;

    // Decoded access always follows the live request
    assign acc.index = addr_to_index(address_i);
    assign acc.wdata = writedata_i[15:0];
    assign acc.be = byteenable_i[1:0];
    // Write lands on the edge at which the master sees waitrequest low
    assign acc.wr_commit = write_i & ~st.waitreq;

    // Answer one cycle after a request appears, then drop back
    always_comb begin
        next_st = st;
        if (!st.waitreq) begin
            next_st.waitreq = 1'b1;
        end else if (read_i || write_i) begin
            next_st.waitreq = 1'b0;
            next_st.rdata = read_i ? acc.rdata : 16'h0000;
        end
    end

    // State register
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '{waitreq: 1'b1, rdata: 16'h0000};
        end else begin
            st <= next_st;
        end
    end

    assign waitrequest_o = st.waitreq;
    assign readdata_o = {16'h0000, st.rdata};
endmodule : avalon_front
`default_nettype wire

// >>> verilog/overlay_key_color_regs.sv
// Purpose: Overlay key colour registers and key function selection
// Assumes: Pixel inputs come from logic on core_clk_i
// Notes:   Selection result is registered, one cycle after the pixel
`timescale 1ns/1ns
`default_nettype none
`include "overlay_key_params.svh"
module overlay_key_color_regs
    import overlay_key_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Avalon-MM slave
    input wire logic [11:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    // Keys held elsewhere in the overlay
    input wire rgb_t trans_key_i,
    input wire rgb_t inv_key_i,
    input wire logic [15:0] or_key_green_blue_i,
    // Pixel stream
    input wire logic pixel_valid_i,
    input wire rgb_t pixel_i,
    // Selection result
    output logic sel_valid_o,
    output key_func_t sel_func_o,
    output logic overlay_on_o
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------

    // Everything the bank remembers
    typedef struct packed {
        logic [7:0] avg_red;      // Average key, red
        logic [7:0] avg_green;    // Average key, green
        logic [7:0] avg_blue;     // Average key, blue
        logic [7:0] and_red;      // AND key, red
        logic [7:0] and_green;    // AND key, green
        logic [7:0] and_blue;     // AND key, blue
        logic [7:0] or_red;       // OR key, red
        logic [15:0] disp_ctrl;   // Display mode and table bypass bits
        logic [4:0] func_en;      // Enables: trans, avg, and, or, inv
        logic sel_valid;          // Registered pixel valid
        key_func_t sel_func;      // Registered chosen function
        logic overlay_on;         // Registered mode decode
    } bank_state_t;

    bank_state_t st;              // Current state
    bank_state_t next_st;         // Next state

    reg_access_if acc();          // Decoded bus accesses

    rgb_t key_col [5];            // Key per function, in rank order
    logic [4:0] hit;              // Match per function, in rank order
    logic mode_ok;                // Overlay sub-window mode is selected

    // ---------------------------------------------------------------
    // Bus front end
    // ---------------------------------------------------------------

    // Handshake and read data live in the front end flops
    avalon_front u_front (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .address_i(address_i),
        .read_i(read_i),
        .write_i(write_i),
        .writedata_i(writedata_i),
        .byteenable_i(byteenable_i),
        .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o),
        .acc(acc)
    );

    // ---------------------------------------------------------------
    // Key matching
    // ---------------------------------------------------------------

    // Keys in rank order, highest first
    always_comb begin
        key_col[0] = trans_key_i;
        key_col[1] = {st.avg_red, st.avg_green, st.avg_blue};
        key_col[2] = {st.and_red, st.and_green, st.and_blue};
        key_col[3] = {st.or_red, or_key_green_blue_i};
        key_col[4] = inv_key_i;
    end

    // One comparator per function
    for (genvar g = 0; g < 5; g++) begin : g_match
        key_match u_match (
            .pixel_i(pixel_i),
            .key_i(key_col[g]),
            .hit_o(hit[g])
        );
    end

    // Mode field decode; all keys are dead outside this mode
    assign mode_ok = (st.disp_ctrl[`MODE_MSB:`MODE_LSB] == `MODE_OVERLAY);

    // ---------------------------------------------------------------
    // Priority selection
    // ---------------------------------------------------------------

    // Highest-ranked function that is enabled and applies here wins
    function automatic key_func_t pick(input logic [4:0] en, input logic [4:0] match);
        logic [4:0] live;
        live = en & match;
        if (live[0]) begin
            return FUNC_TRANS;
        end else if (live[1]) begin
            return FUNC_AVG;
        end else if (live[2]) begin
            return FUNC_AND;
        end else if (live[3]) begin
            return FUNC_OR;
        end else if (live[4]) begin
            return FUNC_INV;
        end else begin
            return FUNC_NONE;
        end
    endfunction : pick

    // ---------------------------------------------------------------
    // Register read mux
    // ---------------------------------------------------------------

    // Unmapped indices read as zero; upper byte of key registers is zero
    always_comb begin
        unique case (acc.index)
            `IDX_DISP_CTRL: begin
                acc.rdata = st.disp_ctrl;
            end
            `IDX_AVG_RED: begin
                acc.rdata = {8'h00, st.avg_red};
            end
            `IDX_AVG_GREEN: begin
                acc.rdata = {8'h00, st.avg_green};
            end
            `IDX_AVG_BLUE: begin
                acc.rdata = {8'h00, st.avg_blue};
            end
            `IDX_AND_RED: begin
                acc.rdata = {8'h00, st.and_red};
            end
            `IDX_AND_GREEN: begin
                acc.rdata = {8'h00, st.and_green};
            end
            `IDX_AND_BLUE: begin
                acc.rdata = {8'h00, st.and_blue};
            end
            `IDX_OR_RED: begin
                acc.rdata = {8'h00, st.or_red};
            end
            `IDX_FUNC_EN: begin
                acc.rdata = {11'h000, st.func_en};
            end
            `IDX_STATUS: begin
                // Live view of the last selection
                acc.rdata = {11'h000, st.overlay_on, st.sel_valid, st.sel_func};
            end
            default: begin
                acc.rdata = 16'h0000;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------

    // Register writes plus the one-cycle selection pipeline
    always_comb begin
        next_st = st;

        // Key bytes sit in lane 0 only
        if (acc.wr_commit && acc.be[0]) begin
            unique case (acc.index)
                `IDX_AVG_RED: begin
                    next_st.avg_red = acc.wdata[7:0];
                end
                `IDX_AVG_GREEN: begin
                    next_st.avg_green = acc.wdata[7:0];
                end
                `IDX_AVG_BLUE: begin
                    next_st.avg_blue = acc.wdata[7:0];
                end
                `IDX_AND_RED: begin
                    next_st.and_red = acc.wdata[7:0];
                end
                `IDX_AND_GREEN: begin
                    next_st.and_green = acc.wdata[7:0];
                end
                `IDX_AND_BLUE: begin
                    next_st.and_blue = acc.wdata[7:0];
                end
                `IDX_OR_RED: begin
                    next_st.or_red = acc.wdata[7:0];
                end
                `IDX_DISP_CTRL: begin
                    next_st.disp_ctrl[7:0] = acc.wdata[7:0];
                end
                `IDX_FUNC_EN: begin
                    next_st.func_en = acc.wdata[4:0];
                end
                default: begin
                    // Unmapped or read-only: the write is dropped
                end
            endcase
        end

        // Upper lane only reaches the display control word
        if (acc.wr_commit && acc.be[1] && acc.index == `IDX_DISP_CTRL) begin
            next_st.disp_ctrl[15:8] = acc.wdata[15:8];
        end

        // Bypass bits are only stored; bit replication is software's job,
        // so a short key written under bypass simply fails to match

        // Selection pipeline: nothing is chosen outside the overlay mode
        next_st.overlay_on = mode_ok;
        next_st.sel_valid = pixel_valid_i;
        if (pixel_valid_i && mode_ok) begin
            next_st.sel_func = pick(st.func_en, hit);
        end else begin
            next_st.sel_func = FUNC_NONE;
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------

    // Everything resets to zero, function none
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '{avg_red: `KEY_RESET, avg_green: `KEY_RESET, avg_blue: `KEY_RESET,
                    and_red: `KEY_RESET, and_green: `KEY_RESET, and_blue: `KEY_RESET,
                    or_red: `KEY_RESET, disp_ctrl: `CTRL_RESET,
                    func_en: `FUNC_EN_RESET, sel_valid: 1'b0,
                    sel_func: FUNC_NONE, overlay_on: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------

    // All straight from the state register
    assign sel_valid_o = st.sel_valid;
    assign sel_func_o = st.sel_func;
    assign overlay_on_o = st.overlay_on;
endmodule : overlay_key_color_regs
`default_nettype wire

// >>> verification/overlay_key_color_regs_properties.sv
// Purpose: Port-level checks on the overlay key bank
// Assumes: One clock, reset asynchronous and active high
// Notes:   Stored keys and enables are not visible here
`timescale 1ns/1ns
`default_nettype none
module overlay_key_color_regs_properties
    import overlay_key_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Register bus
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] readdata_o,
    input wire logic waitrequest_o,
    // Keys and pixels
    input wire rgb_t trans_key_i,
    input wire rgb_t inv_key_i,
    input wire logic [15:0] or_key_green_blue_i,
    input wire logic pixel_valid_i,
    input wire rgb_t pixel_i,
    // Selection
    input wire logic sel_valid_o,
    input wire key_func_t sel_func_o,
    input wire logic overlay_on_o
);
    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    chk_bus_answer: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
        else $error("bus request not answered after one cycle");
    chk_wait_pulse: assert property (!waitrequest_o |=> waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    chk_wait_cause: assert property ($fell(waitrequest_o) |-> $past(read_i || write_i))
        else $error("answer without a request");
    chk_read_upper: assert property (!waitrequest_o |-> readdata_o[31:16] == 16'h0000)
        else $error("upper read data not zero");
    chk_sel_follow: assert property (pixel_valid_i |=> sel_valid_o)
        else $error("pixel result missing");
    chk_sel_quiet: assert property (!pixel_valid_i |=> !sel_valid_o)
        else $error("result without a pixel");
    // Two cycles of mode off cover either registering order of mode and result
    chk_mode_off: assert property ($past(sel_valid_o) && !$past(overlay_on_o) && !overlay_on_o
        |-> $past(sel_func_o) == FUNC_NONE)
        else $error("key function chosen outside overlay mode");
    chk_trans_hit: assert property (sel_func_o == FUNC_TRANS |-> $past(pixel_i) == $past(trans_key_i))
        else $error("transparent chosen without a match");
    chk_inv_hit: assert property (sel_func_o == FUNC_INV |-> $past(pixel_i) == $past(inv_key_i))
        else $error("inverse chosen without a match");
    chk_or_hit: assert property (sel_func_o == FUNC_OR
        |-> $past(pixel_i[15:0]) == $past(or_key_green_blue_i))
        else $error("OR chosen without a match");

    // Main scenarios reached
    cov_avg: cover property (sel_func_o == FUNC_AVG);
    cov_and: cover property (sel_func_o == FUNC_AND);
    cov_write: cover property ($fell(waitrequest_o) && $past(write_i));
endmodule : overlay_key_color_regs_properties
`default_nettype wire

// >>> verification/testbench.sv
// Purpose: Self-checking bench for the overlay key bank
// Assumes: Bus answer and pixel result each come one cycle after the request
// Notes:   Rows cover key selection after the mode sweep; bypass, bus corners and reset follow
`timescale 1ns/1ns
`default_nettype none
`include "overlay_key_params.svh"
module testbench import overlay_key_pkg::*;;
    // ---------------------------------------------------------------
    // Signals and tables
    // ---------------------------------------------------------------
    logic core_clk_i, rst_i, read_i, write_i, pixel_valid_i, waitrequest_o;
    logic sel_valid_o, overlay_on_o;
    logic [11:0] address_i;
    logic [31:0] writedata_i, readdata_o, q;
    logic [3:0] byteenable_i;
    logic [15:0] or_key_green_blue_i;
    rgb_t trans_key_i, inv_key_i, pixel_i;
    key_func_t sel_func_o;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    typedef struct packed {logic [4:0] en; rgb_t trans; rgb_t pix; key_func_t f;} row_t;
    // Keys: avg 112233, and 445566, or 778899, inverse DDEEFF
    row_t rows [10] = '{'{5'h1F, 24'hAABBCC, 24'hAABBCC, FUNC_TRANS},
        '{5'h1F, 24'hAABBCC, 24'h112233, FUNC_AVG}, '{5'h1F, 24'h112233, 24'h112233, FUNC_TRANS},
        '{5'h1E, 24'h112233, 24'h112233, FUNC_AVG}, '{5'h1F, 24'hAABBCC, 24'h445566, FUNC_AND},
        '{5'h1F, 24'hAABBCC, 24'h778899, FUNC_OR}, '{5'h1F, 24'hAABBCC, 24'hDDEEFF, FUNC_INV},
        '{5'h1F, 24'hAABBCC, 24'h112200, FUNC_NONE}, '{5'h10, 24'hAABBCC, 24'h445566, FUNC_NONE},
        '{5'h08, 24'hAABBCC, 24'h778899, FUNC_OR}};
    logic [9:0] key_idx [7] = '{`IDX_AVG_RED, `IDX_AVG_GREEN, `IDX_AVG_BLUE, `IDX_AND_RED,
        `IDX_AND_GREEN, `IDX_AND_BLUE, `IDX_OR_RED};
    logic [7:0] key_val [7] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77};

    overlay_key_color_regs DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .address_i(address_i),
        .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
        .byteenable_i(byteenable_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
        .trans_key_i(trans_key_i), .inv_key_i(inv_key_i),
        .or_key_green_blue_i(or_key_green_blue_i), .pixel_valid_i(pixel_valid_i),
        .pixel_i(pixel_i), .sel_valid_o(sel_valid_o), .sel_func_o(sel_func_o),
        .overlay_on_o(overlay_on_o));

    // Clock of 100 ns period
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    // Hang guard, far above the some 170 cycles the run needs
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            summarize();
        end
    end

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Request held until the rising edge that sees waitrequest low; data taken there
    task automatic bus(input logic wr, input logic [9:0] idx, input logic [15:0] d,
        output logic [31:0] rd);
        @(posedge core_clk_i);
        address_i <= {idx, 2'b00};
        write_i <= wr;
        read_i <= ~wr;
        writedata_i <= {16'h0000, d};
        do begin
            @(posedge core_clk_i);
        end while (waitrequest_o !== 1'b0);
        rd = readdata_o;
        write_i <= 1'b0;
        read_i <= 1'b0;
    endtask : bus

    // One pixel, result checked one edge later
    task automatic pix(input rgb_t p, input key_func_t f);
        pixel_valid_i <= 1'b1;
        pixel_i <= p;
        @(posedge core_clk_i);
        pixel_valid_i <= 1'b0;
        @(negedge core_clk_i);
        check(sel_valid_o, 1'b1);
        check(sel_func_o, f);
        @(posedge core_clk_i);
    endtask : pix

    task automatic summarize();
        $display("checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        read_i = 1'b0;
        write_i = 1'b0;
        address_i = 12'h000;
        writedata_i = 32'h0;
        byteenable_i = 4'hF;
        pixel_valid_i = 1'b0;
        pixel_i = 24'h0;
        trans_key_i = 24'hAABBCC;
        inv_key_i = 24'hDDEEFF;
        or_key_green_blue_i = 16'h8899;
        repeat (8) @(posedge core_clk_i);
        rst_i <= 1'b0;
        // Keys written with a full upper byte, which must read back zero
        for (int i = 0; i < 7; i++) begin
            bus(1'b1, key_idx[i], {8'hFF, key_val[i]}, q);
            bus(1'b0, key_idx[i], 16'h0000, q);
            check(q, {24'h0, key_val[i]});
        end
        // Every display mode: only 11b lets a matching key through
        bus(1'b1, `IDX_FUNC_EN, 16'h001F, q);
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, `IDX_DISP_CTRL, {6'h00, m[1:0], 8'h00}, q);
            pix(24'h112233, (m == 3) ? FUNC_AVG : FUNC_NONE);
            check(overlay_on_o, m == 3);
        end
        // Selection table, mode left at overlay
        foreach (rows[i]) begin
            trans_key_i <= rows[i].trans;
            bus(1'b1, `IDX_FUNC_EN, {11'h000, rows[i].en}, q);
            pix(rows[i].pix, rows[i].f);
        end
        // Table bypass: software widens a 5-bit red by replication before writing
        bus(1'b1, `IDX_DISP_CTRL, 16'h0330, q);
        bus(1'b0, `IDX_DISP_CTRL, 16'h0000, q);
        check(q, 32'h00000330);
        bus(1'b1, `IDX_FUNC_EN, 16'h0002, q);
        bus(1'b1, `IDX_AVG_RED, {8'h00, 5'h15, 3'h5}, q);
        pix(24'hAD2233, FUNC_AVG);
        // Unmapped place: write dropped, read gives zero
        bus(1'b1, 10'h3FF, 16'hFFFF, q);
        bus(1'b0, 10'h3FF, 16'h0000, q);
        check(q, 32'h0);
        // Reset in mid-run raises waitrequest, clears the other outputs and every key
        @(posedge core_clk_i);
        rst_i <= 1'b1;
        @(negedge core_clk_i);
        check(waitrequest_o, 1'b1);
        check(overlay_on_o, 1'b0);
        check(sel_valid_o, 1'b0);
        check(readdata_o, 32'h0);
        @(posedge core_clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            bus(1'b0, key_idx[i], 16'h0000, q);
            check(q, 32'h0);
        end
        summarize();
    end
endmodule : testbench

bind overlay_key_color_regs overlay_key_color_regs_properties u_props (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .read_i(read_i), .write_i(write_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .trans_key_i(trans_key_i),
    .inv_key_i(inv_key_i), .or_key_green_blue_i(or_key_green_blue_i),
    .pixel_valid_i(pixel_valid_i), .pixel_i(pixel_i), .sel_valid_o(sel_valid_o),
    .sel_func_o(sel_func_o), .overlay_on_o(overlay_on_o));
`default_nettype wire
